// [rtl/l1_tag_shadow_snoop_filter.v]
// snoop filter: shadow l1 tag directories plus copy-back address fifo
// assumes processor bus inputs are synchronous to clock_in and last one cycle;
// system snoop inputs are synchronous to clock_in as well
`timescale 1ns/100ps
`default_nettype none
`include "snoop_filter_consts.vh"

module l1_tag_shadow_snoop_filter (
  input wire clock_in,
  input wire sys_rst_in,
  // configuration
  input wire state_track_en_in,
  input wire global_valid_en_in,
  input wire cb_kill_clear_en_in,
  // processor bus operation
  input wire proc_op_valid_in,
  input wire [`OP_W-1:0] proc_op_in,
  input wire [`ADDR_W-1:0] proc_addr_in,
  input wire proc_inst_in,
  input wire cache_inhibit_n_in,
  input wire [`WAY_W-1:0] way_select_in,
  input wire proc_global_flag_in,
  input wire proc_shared_in,
  input wire proc_castout_in,
  input wire transfer_code_bit0_in,
  input wire transfer_code_bit2_in,
  // system snoop
  input wire snoop_valid_in,
  input wire [`ADDR_W-1:0] snoop_addr_in,
  input wire system_global_flag_in,
  input wire snoop_is_mem_in,
  input wire snoop_is_read_in,
  input wire l2_hit_in,
  input wire proc_snoop_done_in,
  output wire snoop_ready_out,
  output reg fwd_valid_out,
  output reg [`ADDR_W-1:0] fwd_addr_out,
  output reg l2_intervene_out,
  output reg system_shared_resp_out,
  output reg no_intervene_out,
  output reg reeval_out
);

  // ======================================================
  // processor operation decode
  wire [`TAG_W-1:0] p_tag = proc_addr_in[`TAG_HI:`TAG_LO];
  wire [`SET_W-1:0] p_set = proc_addr_in[`SET_HI:`SET_LO];
  wire op_rd = proc_op_valid_in & (proc_op_in == `OP_READ);
  wire op_rfm = proc_op_valid_in & (proc_op_in == `OP_READ_FOR_MODIFY);
  wire op_wk = proc_op_valid_in & (proc_op_in == `OP_WRITE_KILL);
  wire op_kb = proc_op_valid_in & (proc_op_in == `OP_KILL_BLOCK);
  wire op_ic = proc_op_valid_in & (proc_op_in == `OP_ICACHE_INVAL);
  wire op_fl = proc_op_valid_in & (proc_op_in == `OP_FLUSH);

  // atomic forms share the read codes; inhibited reads never allocate
  wire rd_alloc = (op_rd | op_rfm) & cache_inhibit_n_in;
  wire i_alloc = rd_alloc & proc_inst_in;
  wire d_rd_alloc = rd_alloc & ~proc_inst_in;

  wire d_prc_hit;
  wire [`WAY_W-1:0] d_prc_way;
  wire i_prc_hit;
  wire [`WAY_W-1:0] i_prc_way;
  wire [`TAG_W-1:0] d_old_tag;
  wire d_old_valid;

  // kill block: bit zero set deallocates, clear allocates or retains
  wire kb_dealloc = op_kb & transfer_code_bit0_in;
  wire kb_alloc = op_kb & ~transfer_code_bit0_in & ~d_prc_hit;
  wire kb_retain = op_kb & ~transfer_code_bit0_in & d_prc_hit;
  wire wk_dealloc = op_wk & transfer_code_bit0_in;

  wire d_alloc = d_rd_alloc | kb_alloc;
  wire d_dealloc = (kb_dealloc | wk_dealloc | op_fl) & d_prc_hit;
  wire i_dealloc = op_ic & i_prc_hit;

  // valid loads from the global flag when enabled, otherwise one
  wire alloc_valid = global_valid_en_in ? proc_global_flag_in : 1'b1;
  // shared only for plain reads that saw a shared answer; rest exclusive
  wire alloc_shared = state_track_en_in & op_rd & proc_shared_in;

  // copy-back buffer use: castout flag on reads, bit two on block zero
  wire cb_push = (d_rd_alloc & proc_castout_in) |
                 (kb_alloc & transfer_code_bit2_in);

  // ======================================================
  // write port muxing for the data shadow
  wire d_wr_en = d_alloc | kb_retain | d_dealloc;
  wire [`WAY_W-1:0] d_wr_way = d_alloc ? way_select_in : d_prc_way;
  wire d_wr_valid = d_alloc ? alloc_valid : kb_retain;
  // a retained kill moves the line to exclusive-or-modified
  wire d_wr_shared = d_alloc ? alloc_shared : 1'b0;

  // ======================================================
  // snoop capture and lookup
  reg [`ST_W-1:0] st_ff;
  reg [`ST_W-1:0] nxt_st;
  reg [`ADDR_W-1:0] snp_addr_ff;
  reg snp_global_ff;
  reg snp_mem_ff;
  reg snp_read_ff;

  wire [`TAG_W-1:0] s_tag = snp_addr_ff[`TAG_HI:`TAG_LO];
  wire [`SET_W-1:0] s_set = snp_addr_ff[`SET_HI:`SET_LO];
  wire d_snp_hit;
  wire d_snp_shared;
  wire i_snp_hit;
  wire [`CB_COUNT-1:0] cb_snp_hits;
  wire cb_snp_hit = |cb_snp_hits;

  // ======================================================
  // shadow directories
  shadow_dir u_dshadow (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .rd_set_in(p_set),
    .rd_way_in(way_select_in),
    .rd_tag_out(d_old_tag),
    .rd_valid_out(d_old_valid),
    .wr_en_in(d_wr_en),
    .wr_set_in(p_set),
    .wr_way_in(d_wr_way),
    .wr_tag_in(p_tag),
    .wr_valid_in(d_wr_valid),
    .wr_shared_in(d_wr_shared),
    .snp_set_in(s_set),
    .snp_tag_in(s_tag),
    .snp_hit_out(d_snp_hit),
    .snp_shared_out(d_snp_shared),
    .prc_set_in(p_set),
    .prc_tag_in(p_tag),
    .prc_hit_out(d_prc_hit),
    .prc_way_out(d_prc_way)
  );

  shadow_dir u_ishadow (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .rd_set_in(p_set),
    .rd_way_in(way_select_in),
    .rd_tag_out(),
    .rd_valid_out(),
    .wr_en_in(i_alloc | i_dealloc),
    .wr_set_in(p_set),
    .wr_way_in(i_alloc ? way_select_in : i_prc_way),
    .wr_tag_in(p_tag),
    .wr_valid_in(i_alloc ? alloc_valid : 1'b0),
    .wr_shared_in(1'b0),
    .snp_set_in(s_set),
    .snp_tag_in(s_tag),
    .snp_hit_out(i_snp_hit),
    .snp_shared_out(),
    .prc_set_in(p_set),
    .prc_tag_in(p_tag),
    .prc_hit_out(i_prc_hit),
    .prc_way_out(i_prc_way)
  );

  // ======================================================
  // copy-back address fifo: the fifth data slot
  reg [`CB_PTR_W-1:0] cb_ptr_ff;
  wire [`LINE_W-1:0] displaced_line = {d_old_tag, p_set};
  wire [`LINE_W-1:0] p_line = {p_tag, p_set};
  wire [`LINE_W-1:0] s_line = {s_tag, s_set};
  wire cb_kill = op_wk & cb_kill_clear_en_in;

  genvar c;
  generate
    for (c = 0; c < `CB_COUNT; c = c + 1) begin : g_cb
      localparam integer CB_IDX = c;
      cb_addr_reg u_cb (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .load_in(cb_push & (cb_ptr_ff == CB_IDX[`CB_PTR_W-1:0])),
        .line_in(displaced_line),
        .valid_in(d_old_valid),
        .kill_in(cb_kill),
        .snp_line_in(s_line),
        .prc_line_in(p_line),
        .snp_hit_out(cb_snp_hits[c]),
        .prc_hit_out()
      );
    end
  endgenerate

  // the pointer wraps, so a full fifo overwrites its oldest entry
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      cb_ptr_ff <= `CB_PTR_RST;
    end else if (cb_push) begin
      if (cb_ptr_ff == `CB_COUNT - 1) begin
        cb_ptr_ff <= {`CB_PTR_W{1'b0}};
      end else begin
        cb_ptr_ff <= cb_ptr_ff + 1'b1;
      end
    end
  end

  // ======================================================
  // snoop decision
  wire shadow_hit = i_snp_hit | d_snp_hit | cb_snp_hit;
  wire need_proc = snp_global_ff & shadow_hit;
  // a copy-back or instruction hit still needs the processor
  wire shared_direct = state_track_en_in & snp_read_ff & d_snp_shared &
                       ~i_snp_hit & ~cb_snp_hit;

  assign snoop_ready_out = (st_ff == `ST_IDLE);

  always @* begin
    nxt_st = st_ff;
    case (st_ff)
      `ST_IDLE: begin
        if (snoop_valid_in) begin
          nxt_st = `ST_LOOK;
        end
      end
      `ST_LOOK: begin
        if (~snp_mem_ff) begin
          nxt_st = `ST_FWD;
        end else if (need_proc & ~shared_direct) begin
          nxt_st = `ST_FWD;
        end else begin
          nxt_st = `ST_IDLE;
        end
      end
      `ST_FWD: begin
        if (proc_snoop_done_in) begin
          nxt_st = `ST_IDLE;
        end
      end
      default: begin
        nxt_st = `ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_ff <= `ST_IDLE;
      snp_addr_ff <= {`ADDR_W{1'b0}};
      snp_global_ff <= 1'b0;
      snp_mem_ff <= 1'b0;
      snp_read_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (snoop_ready_out & snoop_valid_in) begin
        snp_addr_ff <= snoop_addr_in;
        snp_global_ff <= system_global_flag_in;
        snp_mem_ff <= snoop_is_mem_in;
        snp_read_ff <= snoop_is_read_in;
      end
    end
  end

  // ======================================================
  // registered responses, each a one-cycle pulse except fwd_addr_out, which holds its last value
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      fwd_valid_out <= 1'b0;
      fwd_addr_out <= {`ADDR_W{1'b0}};
      l2_intervene_out <= 1'b0;
      system_shared_resp_out <= 1'b0;
      no_intervene_out <= 1'b0;
      reeval_out <= 1'b0;
    end else begin
      fwd_valid_out <= 1'b0;
      l2_intervene_out <= 1'b0;
      system_shared_resp_out <= 1'b0;
      no_intervene_out <= 1'b0;
      reeval_out <= 1'b0;
      if (st_ff == `ST_LOOK) begin
        if (~snp_mem_ff) begin
          fwd_valid_out <= 1'b1;
          fwd_addr_out <= snp_addr_ff;
        end else if (need_proc & shared_direct) begin
          system_shared_resp_out <= 1'b1;
        end else if (need_proc) begin
          fwd_valid_out <= 1'b1;
          fwd_addr_out <= snp_addr_ff;
        end else if (l2_hit_in) begin
          l2_intervene_out <= 1'b1;
        end else begin
          no_intervene_out <= 1'b1;
        end
      end
      if ((st_ff == `ST_FWD) & proc_snoop_done_in) begin
        // rerun against l2 state the processor may have changed
        reeval_out <= 1'b1;
        l2_intervene_out <= l2_hit_in;
        no_intervene_out <= ~l2_hit_in;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/snoop_filter_consts.vh]
// constants for the l1 tag shadow snoop filter
// assumes a 32-bit physical address and 32-byte cache lines
// Contract
// - snoop checks shadow and l2 together; no hit anywhere means no intervention
// - l2 hit with shadow miss: l2 controller answers the system bus itself
// - shadow hit forwards snoop to processor, then re-evaluates against l2 state
// - instruction and data shadows: four ways, 128 sets, valid plus 20-bit tag
// - all shadow valid flags cleared at power-up
// - shadow array reads, writes, and compares tag and valid against one
// - one write-and-compare copy-back address register per processor copy-back buffer
// - cacheable reads and read-for-modify allocate at way select and address set
// - data shadow is four plus one; instruction shadow plain four-way
// - transfer code bit zero separates deallocating kills from allocating or retaining
// - displaced entry saved into copy-back registers in first-in first-out order
// - copy-back register valid starts clear, loads from displaced shadow valid
// - optionally a matching write-with-kill clears copy-back register valid
// - global snoops compare shadow and copy-back registers; hit forwards, else completes
// - optionally allocation valid loads from processor global flag; snoops compare one
// - non-memory system operations bypass filtering and go to the processor
// - state variant keeps only invalid, shared, or exclusive-or-modified per line
// - state variant adds a shared flag to each data shadow entry
// - state variant answers system reads to shared lines with shared response
`ifndef SNOOP_FILTER_CONSTS_VH
`define SNOOP_FILTER_CONSTS_VH

// ======================================================
// address layout
`define ADDR_W 32
`define TAG_HI 31
`define TAG_LO 12
`define TAG_W 20
`define SET_HI 11
`define SET_LO 5
`define SET_W 7
`define SETS 128
`define WAYS 4
`define WAY_W 2
`define IDX_W 9
`define ENTRIES 512
`define LINE_W 27

// ======================================================
// copy-back address registers
`define CB_COUNT 2
`define CB_PTR_W 1
`define CB_PTR_RST 1'h0

// ======================================================
// processor bus operation codes
`define OP_W 3
`define OP_READ 3'h0
`define OP_READ_FOR_MODIFY 3'h1
`define OP_WRITE_KILL 3'h2
`define OP_KILL_BLOCK 3'h3
`define OP_ICACHE_INVAL 3'h4
`define OP_FLUSH 3'h5

// ======================================================
// snoop sequencer states, one-hot
`define ST_W 3
`define ST_IDLE 3'h1
`define ST_LOOK 3'h2
`define ST_FWD 3'h4

`endif

// [rtl/shadow_dir.v]
// one shadow tag directory: 4 ways x 128 sets of valid, shared flag and tag
// assumes the caller never writes and compares the same entry expecting old data
`timescale 1ns/100ps
`default_nettype none
`include "snoop_filter_consts.vh"

module shadow_dir (
  input wire clock_in,
  input wire sys_rst_in,
  input wire [`SET_W-1:0] rd_set_in,
  input wire [`WAY_W-1:0] rd_way_in,
  output wire [`TAG_W-1:0] rd_tag_out,
  output wire rd_valid_out,
  input wire wr_en_in,
  input wire [`SET_W-1:0] wr_set_in,
  input wire [`WAY_W-1:0] wr_way_in,
  input wire [`TAG_W-1:0] wr_tag_in,
  input wire wr_valid_in,
  input wire wr_shared_in,
  input wire [`SET_W-1:0] snp_set_in,
  input wire [`TAG_W-1:0] snp_tag_in,
  output wire snp_hit_out,
  output wire snp_shared_out,
  input wire [`SET_W-1:0] prc_set_in,
  input wire [`TAG_W-1:0] prc_tag_in,
  output wire prc_hit_out,
  output reg [`WAY_W-1:0] prc_way_out
);

  reg [`TAG_W-1:0] tag_mem [0:`ENTRIES-1];
  reg [`ENTRIES-1:0] valid_ff;
  reg [`ENTRIES-1:0] shared_ff;
  wire [`WAYS-1:0] snp_match;
  wire [`WAYS-1:0] snp_shr;
  wire [`WAYS-1:0] prc_match;
  wire [`IDX_W-1:0] wr_idx = {wr_set_in, wr_way_in};
  wire [`IDX_W-1:0] rd_idx = {rd_set_in, rd_way_in};
  integer i;

  assign rd_tag_out = tag_mem[rd_idx];
  assign rd_valid_out = valid_ff[rd_idx];

  // ======================================================
  // eight 21-bit compares per directory, four for snoops and four for the processor
  genvar w;
  generate
    for (w = 0; w < `WAYS; w = w + 1) begin : g_way
      localparam integer WI = w;
      wire [`IDX_W-1:0] si = {snp_set_in, WI[`WAY_W-1:0]};
      wire [`IDX_W-1:0] pi = {prc_set_in, WI[`WAY_W-1:0]};
      assign snp_match[w] = {valid_ff[si], tag_mem[si]} == {1'b1, snp_tag_in};
      assign snp_shr[w] = snp_match[w] & shared_ff[si];
      assign prc_match[w] = {valid_ff[pi], tag_mem[pi]} == {1'b1, prc_tag_in};
    end
  endgenerate

  assign snp_hit_out = |snp_match;
  assign snp_shared_out = |snp_shr;
  assign prc_hit_out = |prc_match;

  always @* begin
    prc_way_out = {`WAY_W{1'b0}};
    for (i = 0; i < `WAYS; i = i + 1) begin
      if (prc_match[i]) begin
        prc_way_out = i[`WAY_W-1:0];
      end
    end
  end

  // ======================================================
  // storage; tags need no reset since a clear valid masks them
  always @(posedge clock_in) begin
    if (wr_en_in) begin
      tag_mem[wr_idx] <= wr_tag_in;
    end
  end

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      valid_ff <= {`ENTRIES{1'b0}};
      shared_ff <= {`ENTRIES{1'b0}};
    end else if (wr_en_in) begin
      valid_ff[wr_idx] <= wr_valid_in;
      shared_ff[wr_idx] <= wr_shared_in;
    end
  end

endmodule
`default_nettype wire

// [rtl/cb_addr_reg.v]
// one copy-back address register with its own comparators
// assumes load and kill come from the processor-side decode of the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "snoop_filter_consts.vh"

module cb_addr_reg (
  input wire clock_in,
  input wire sys_rst_in,
  input wire load_in,
  input wire [`LINE_W-1:0] line_in,
  input wire valid_in,
  input wire kill_in,
  input wire [`LINE_W-1:0] snp_line_in,
  input wire [`LINE_W-1:0] prc_line_in,
  output wire snp_hit_out,
  output wire prc_hit_out
);

  reg [`LINE_W-1:0] line_ff;
  reg valid_ff;

  // write and compare only; no read path is needed
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      line_ff <= {`LINE_W{1'b0}};
      valid_ff <= 1'b0;
    end else if (load_in) begin
      line_ff <= line_in;
      valid_ff <= valid_in;
    end else if (kill_in & prc_hit_out) begin
      valid_ff <= 1'b0;
    end
  end

  assign snp_hit_out = valid_ff & (line_ff == snp_line_in);
  assign prc_hit_out = valid_ff & (line_ff == prc_line_in);

endmodule
`default_nettype wire

// [verification/l1_tag_shadow_snoop_filter_props.sv]
// checker for the snoop filter top: snoop answer timing and choice
// assumes the top module ports and the shared constants header
`timescale 1ns/100ps
`default_nettype none
`include "snoop_filter_consts.vh"

// ======================================================
// snoop answer properties
module snoop_filter_props (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic state_track_en_in,
  input wire logic snoop_valid_in,
  input wire logic [`ADDR_W-1:0] snoop_addr_in,
  input wire logic system_global_flag_in,
  input wire logic snoop_is_mem_in,
  input wire logic snoop_is_read_in,
  input wire logic l2_hit_in,
  input wire logic proc_snoop_done_in,
  input wire logic snoop_ready_out,
  input wire logic fwd_valid_out,
  input wire logic [`ADDR_W-1:0] fwd_addr_out,
  input wire logic l2_intervene_out,
  input wire logic system_shared_resp_out,
  input wire logic no_intervene_out,
  input wire logic reeval_out
);
  logic taken;
  logic fwd_pend_ff;
  assign taken = snoop_valid_in & snoop_ready_out;
  // a forward stays open until its re-evaluation pulse
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) fwd_pend_ff <= 1'b0;
    else if (fwd_valid_out) fwd_pend_ff <= 1'b1;
    else if (reeval_out) fwd_pend_ff <= 1'b0;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  property p_busy;
    taken |=> !snoop_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready stayed high in lookup");
  property p_one_answer;
    taken |-> ##2 $onehot({fwd_valid_out, l2_intervene_out, system_shared_resp_out,
      no_intervene_out});
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("not exactly one answer");
  property p_nonmem_fwd;
    taken && !snoop_is_mem_in |-> ##2 fwd_valid_out && fwd_addr_out == $past(snoop_addr_in, 2);
  endproperty
  a_nonmem_fwd: assert property (p_nonmem_fwd) else $error("non-memory snoop not passed");
  property p_l2_only;
    taken && snoop_is_mem_in && !system_global_flag_in ##1 l2_hit_in |=> l2_intervene_out;
  endproperty
  a_l2_only: assert property (p_l2_only) else $error("l2 hit without intervention");
  property p_no_hit;
    taken && snoop_is_mem_in && !system_global_flag_in ##1 !l2_hit_in |=> no_intervene_out;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("miss did not complete quietly");
  property p_reeval;
    (fwd_valid_out || fwd_pend_ff) && proc_snoop_done_in |=> reeval_out
      && l2_intervene_out == $past(l2_hit_in) && no_intervene_out != $past(l2_hit_in);
  endproperty
  a_reeval: assert property (p_reeval) else $error("bad re-evaluation");
  property p_reeval_cause;
    reeval_out |-> $past(proc_snoop_done_in);
  endproperty
  a_reeval_cause: assert property (p_reeval_cause) else $error("re-evaluation uncaused");
  property p_shared;
    system_shared_resp_out |-> $past(state_track_en_in) && $past(snoop_is_read_in, 2)
      && $past(system_global_flag_in, 2);
  endproperty
  a_shared: assert property (p_shared) else $error("shared answer without cause");
  property p_rst;
    disable iff (1'b0) sys_rst_in |=> !fwd_valid_out && !reeval_out && snoop_ready_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left snoop path busy");
  c_fwd: cover property (fwd_valid_out);
  c_shared: cover property (system_shared_resp_out);
  c_reeval: cover property (reeval_out && l2_intervene_out);
endmodule

bind l1_tag_shadow_snoop_filter snoop_filter_props u_props (.clock_in, .sys_rst_in,
  .state_track_en_in, .snoop_valid_in, .snoop_addr_in, .system_global_flag_in,
  .snoop_is_mem_in, .snoop_is_read_in, .l2_hit_in, .proc_snoop_done_in, .snoop_ready_out,
  .fwd_valid_out, .fwd_addr_out, .l2_intervene_out, .system_shared_resp_out,
  .no_intervene_out, .reeval_out);
`default_nettype wire

// [verification/proc_snoop_responder.sv]
// processor side of the snoop path: answers each forwarded snoop
// assumes fwd_in is a one-cycle pulse launched on the rising edge
`timescale 1ns/100ps
`default_nettype none

// ======================================================
// snoop responder
module proc_snoop_responder (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic fwd_in,
  input wire logic [3:0] delay_in,
  output logic done_out
);
  logic [3:0] wait_ff;
  logic busy_ff;
  initial done_out = 1'b0;
  // falling edge, like every other bench input; zero delay answers at once
  always @(negedge clock_in) begin
    done_out <= 1'b0;
    if (sys_rst_in) begin
      busy_ff <= 1'b0;
      wait_ff <= 4'h0;
    end else if (fwd_in && delay_in == 4'h0) begin
      done_out <= 1'b1;
    end else if (fwd_in) begin
      busy_ff <= 1'b1;
      wait_ff <= delay_in;
    end else if (busy_ff && wait_ff == 4'h1) begin
      done_out <= 1'b1;
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_l1_tag_shadow_snoop_filter.sv]
// self-checking bench for the snoop filter
// assumes the design, the checker and the responder model compile beside it
`timescale 1ns/100ps
`default_nettype none
`include "snoop_filter_consts.vh"

// ======================================================
// bench top
module tb_l1_tag_shadow_snoop_filter;
  localparam logic [2:0] no_op = 3'h7;
  logic clock_in;
  logic sys_rst_in = 1'b1, state_track_en_in = 1'b0, global_valid_en_in = 1'b0;
  logic cb_kill_clear_en_in = 1'b0, proc_op_valid_in = 1'b0, proc_inst_in = 1'b0;
  logic [`OP_W-1:0] proc_op_in = 3'h0;
  logic [`ADDR_W-1:0] proc_addr_in = 32'h0, snoop_addr_in = 32'h0, fwd_addr_out;
  logic [`WAY_W-1:0] way_select_in = 2'h0;
  logic cache_inhibit_n_in = 1'b1, proc_global_flag_in = 1'b0, proc_shared_in = 1'b0;
  logic proc_castout_in = 1'b0, transfer_code_bit0_in = 1'b0, transfer_code_bit2_in = 1'b0;
  logic snoop_valid_in = 1'b0, system_global_flag_in = 1'b0, snoop_is_mem_in = 1'b0;
  logic snoop_is_read_in = 1'b0, l2_hit_in = 1'b0;
  wire proc_snoop_done_in;
  logic snoop_ready_out, fwd_valid_out, l2_intervene_out, system_shared_resp_out;
  logic no_intervene_out, reeval_out;
  logic [3:0] resp_delay = 4'h0;
  int n_errors = 0, n_checks = 0, cycles = 0;
  // pf: inst, inhibit_n, way, global, shared, castout, code0, code2; sf: global, mem, read, l2 hit
  // ans: 0 forward, 1 l2 intervenes, 2 shared answer, 3 no intervention
  typedef struct packed {
    logic [2:0] cfg;
    logic [2:0] op;
    logic [31:0] pa;
    logic [8:0] pf;
    logic [31:0] sa;
    logic [3:0] sf;
    logic [1:0] ans;
  } row_t;
  row_t rows[$];

  l1_tag_shadow_snoop_filter u_dut (.clock_in, .sys_rst_in, .state_track_en_in,
    .global_valid_en_in, .cb_kill_clear_en_in, .proc_op_valid_in, .proc_op_in, .proc_addr_in,
    .proc_inst_in, .cache_inhibit_n_in, .way_select_in, .proc_global_flag_in,
    .proc_shared_in, .proc_castout_in, .transfer_code_bit0_in, .transfer_code_bit2_in,
    .snoop_valid_in, .snoop_addr_in, .system_global_flag_in, .snoop_is_mem_in,
    .snoop_is_read_in, .l2_hit_in, .proc_snoop_done_in, .snoop_ready_out, .fwd_valid_out,
    .fwd_addr_out, .l2_intervene_out, .system_shared_resp_out, .no_intervene_out,
    .reeval_out);
  proc_snoop_responder u_resp (.clock_in, .sys_rst_in, .fwd_in(fwd_valid_out),
    .delay_in(resp_delay), .done_out(proc_snoop_done_in));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // a hung handshake ends the run here; a full pass needs well under two hundred cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end

  // ======================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one processor op, then one snoop, then its answer and any re-evaluation
  task automatic run_row(input row_t r, input int i);
    int k;
    {state_track_en_in, global_valid_en_in, cb_kill_clear_en_in} = r.cfg;
    proc_op_valid_in = (r.op != no_op);
    proc_op_in = r.op;
    proc_addr_in = r.pa;
    {proc_inst_in, cache_inhibit_n_in, way_select_in, proc_global_flag_in, proc_shared_in,
      proc_castout_in, transfer_code_bit0_in, transfer_code_bit2_in} = r.pf;
    resp_delay = i[0] ? 4'h3 : 4'h0;
    @(negedge clock_in);
    proc_op_valid_in = 1'b0;
    chk("ready", snoop_ready_out, 1'b1);
    snoop_valid_in = 1'b1;
    snoop_addr_in = r.sa;
    {system_global_flag_in, snoop_is_mem_in, snoop_is_read_in, l2_hit_in} = r.sf;
    @(negedge clock_in);
    snoop_valid_in = 1'b0;
    @(negedge clock_in);
    chk("answer", {fwd_valid_out, l2_intervene_out, system_shared_resp_out,
      no_intervene_out}, 4'h8 >> r.ans);
    if (r.ans == 2'h0) begin
      chk("forward address", fwd_addr_out, r.sa);
      // l2 state changes while the processor answers
      l2_hit_in = ~r.sf[0];
      for (k = 0; k < 8 && reeval_out !== 1'b1; k++) @(negedge clock_in);
      chk("re-evaluation", reeval_out, 1'b1);
      chk("final answer", {l2_intervene_out, no_intervene_out}, {~r.sf[0], r.sf[0]});
      @(negedge clock_in);
    end
    $display("row %0d done", i);
  endtask

  // ======================================================
  // main sequence
  initial begin
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00001020, 4'he, 2'h3});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00001020, 4'hf, 2'h3 - 2'h2});
    rows.push_back({3'h0, `OP_READ, 32'h00001020, 9'h090, 32'h00001020, 4'hf, 2'h0});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00001020, 4'h5, 2'h1});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00001020, 4'h4, 2'h3});
    rows.push_back({3'h0, `OP_READ, 32'h00002020, 9'h010, 32'h00002020, 4'he, 2'h3});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h0, 4'h8, 2'h0});
    rows.push_back({3'h0, `OP_READ, 32'h00003040, 9'h190, 32'h00003040, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_READ_FOR_MODIFY, 32'h00004020, 9'h094, 32'h00001020, 4'he,
      2'h0});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00004020, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_KILL_BLOCK, 32'h00004020, 9'h092, 32'h00004020, 4'he, 2'h3});
    rows.push_back({3'h1, `OP_WRITE_KILL, 32'h00001020, 9'h092, 32'h00001020, 4'he, 2'h3});
    rows.push_back({3'h2, `OP_READ, 32'h00005020, 9'h080, 32'h00005020, 4'he, 2'h3});
    rows.push_back({3'h4, `OP_READ, 32'h00006060, 9'h098, 32'h00006060, 4'he, 2'h2});
    rows.push_back({3'h4, `OP_KILL_BLOCK, 32'h00006060, 9'h090, 32'h00006060, 4'he, 2'h0});
    rows.push_back({3'h4, no_op, 32'h0, 9'h090, 32'h00006060, 4'hc, 2'h0});
    rows.push_back({3'h0, `OP_KILL_BLOCK, 32'h00007060, 9'h091, 32'h00006060, 4'hc,
      2'h0});
    rows.push_back({3'h0, no_op, 32'h0, 9'h090, 32'h00007060, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_FLUSH, 32'h00007060, 9'h090, 32'h00007060, 4'he, 2'h3});
    rows.push_back({3'h0, `OP_ICACHE_INVAL, 32'h00003040, 9'h190, 32'h00003040, 4'he,
      2'h3});
    rows.push_back({3'h0, `OP_READ, 32'h00008040, 9'h0b0, 32'h00008040, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_READ, 32'h00009040, 9'h0b4, 32'h00008040, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_READ, 32'h0000a040, 9'h0b4, 32'h00009040, 4'he, 2'h0});
    rows.push_back({3'h0, `OP_READ, 32'h0000b040, 9'h0b4, 32'h00008040, 4'he, 2'h3});
    repeat (3) @(negedge clock_in);
    sys_rst_in = 1'b0;
    foreach (rows[i]) run_row(rows[i], i);
    // ======================================================
    // mid-run reset must empty the shadow that still holds the last line
    sys_rst_in = 1'b1;
    @(negedge clock_in);
    sys_rst_in = 1'b0;
    chk("ready after reset", snoop_ready_out, 1'b1);
    run_row({3'h0, no_op, 32'h0, 9'h090, 32'h0000b040, 4'he, 2'h3}, 99);
    conclude();
  end
endmodule
`default_nettype wire
